// ---- logic/dfr_pkg.sv ----
package dfr_pkg;

  // ---------------------------------------------------------------
  // register byte addresses (index times four)
  // ---------------------------------------------------------------
  localparam logic [4:0] DFR_ANALOG_INDEX = 5'h15;
  localparam logic [4:0] DFR_DIGITAL_INDEX = 5'h14;
  localparam logic [7:0] DFR_ANALOG_ADDR = 8'h54;
  localparam logic [7:0] DFR_DIGITAL_ADDR = 8'h50;
  localparam logic [7:0] DFR_IRQ_STATUS_ADDR = 8'h60;
  localparam logic [7:0] DFR_IRQ_MASK_ADDR = 8'h64;
  localparam logic [7:0] DFR_ENABLE_ADDR = 8'h68;

  // ---------------------------------------------------------------
  // analog word layout
  // ---------------------------------------------------------------
  localparam int DFR_ANALOG_WIDTH = 22;
  localparam int DFR_FAULT_PIN_BIT = 21;
  localparam int DFR_ADDR_LSB = 16;
  localparam int DFR_ADDR_MSB = 20;
  localparam logic [13:0] DFR_ANALOG_FLAG_MASK = 14'h2BFF;
  localparam logic [21:0] DFR_ANALOG_RESET = 22'h150000;
  localparam logic [13:0] DFR_ENABLE_RESET = 14'h3FFF;

  // ---------------------------------------------------------------
  // digital word layout
  // ---------------------------------------------------------------
  localparam int DFR_CRC_BIT = 0;
  localparam int DFR_SLIP_BIT = 1;
  localparam logic [1:0] DFR_DIGITAL_RESET = 2'h0;

  // interrupt status: bit 0 any analog flag, bit 1 any digital flag
  localparam logic [1:0] DFR_IRQ_RESET = 2'h0;

  // ---------------------------------------------------------------
  // axi responses
  // ---------------------------------------------------------------
  localparam logic [1:0] DFR_RESP_OKAY = 2'h0;
  localparam logic [1:0] DFR_RESP_SLVERR = 2'h2;

endpackage

// ---- logic/dfr_flags.sv ----
// What this block does
// - slip flag when word msb equals next bit
// - crc flag when received frame fails check
// - analog flags sticky, write one clears
// - disabled diagnostic reads back as zero
// - bit 21 shows inverted fault pin
// - bit 13 output outside rails
// - bit 11 converter short circuit
// - bit 9 converter cannot reach rail
// - bit 8 regulator capacitor missing
// - bit 7 open circuit or no headroom
// - bit 6 voltage output short
// - bits 5 and 4 die overtemperature
// - bits 3 and 0 reference/regulator node fault
// - bit 2 reference input out of window
// - bit 1 internal supply out of window
`timescale 1ns/1ns
`default_nettype none
module dfr_flags #(
  // flag counts; the port widths and the register map serve only these sizes
  parameter int FLAG_COUNT = 14,
  parameter int DIGITAL_COUNT = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // analog fault events, one per flag bit, level or pulse
  input wire logic [13:0] analog_event,
  // received serial word check
  input wire logic frame_valid,
  input wire logic frame_msb,
  input wire logic frame_msb_less1,
  input wire logic frame_crc_bad,
  // fault pin level
  input wire logic fault_pin,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  import dfr_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // other sizes would leave flags without a bit position in the word
  if (FLAG_COUNT != 14) begin : g_bad_flag_count
    $error("dfr_flags: FLAG_COUNT must be 14");
  end
  if (DIGITAL_COUNT != 2) begin : g_bad_digital_count
    $error("dfr_flags: DIGITAL_COUNT must be 2");
  end

  logic [13:0] analog_flags;
  logic [1:0] digital_flags;
  logic [13:0] diag_enable;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [13:0] clr_analog;
  logic [1:0] clr_digital;
  logic [1:0] clr_irq;
  logic [13:0] set_analog;
  logic [1:0] set_digital;
  logic [21:0] analog_word;
  logic [31:0] next_rdata;
  logic next_rresp_err;
  logic [13:0] flag_view;
  logic [1:0] irq_source;
  logic wsel_analog;
  logic wsel_digital;
  logic wsel_irq_status;
  logic wsel_irq_mask;
  logic wsel_enable;
  logic wsel_mapped;
  logic rsel_analog;
  logic rsel_digital;
  logic rsel_irq_status;
  logic rsel_irq_mask;
  logic rsel_enable;
  logic rsel_mapped;
  logic [31:0] rv_analog;
  logic [31:0] rv_digital;
  logic [31:0] rv_irq_status;
  logic [31:0] rv_irq_mask;
  logic [31:0] rv_enable;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // the write side decodes the held address, so the master may change
  // awaddr as soon as it is taken without disturbing the pending write
  assign wsel_analog = (aw_addr == DFR_ANALOG_ADDR);
  assign wsel_digital = (aw_addr == DFR_DIGITAL_ADDR);
  assign wsel_irq_status = (aw_addr == DFR_IRQ_STATUS_ADDR);
  assign wsel_irq_mask = (aw_addr == DFR_IRQ_MASK_ADDR);
  assign wsel_enable = (aw_addr == DFR_ENABLE_ADDR);
  assign wsel_mapped = wsel_analog || wsel_digital || wsel_irq_status
    || wsel_irq_mask || wsel_enable;

  // the read side decodes the live address; it is only used on the
  // edge at which the read address is taken
  assign rsel_analog = (s_axi_araddr == DFR_ANALOG_ADDR);
  assign rsel_digital = (s_axi_araddr == DFR_DIGITAL_ADDR);
  assign rsel_irq_status = (s_axi_araddr == DFR_IRQ_STATUS_ADDR);
  assign rsel_irq_mask = (s_axi_araddr == DFR_IRQ_MASK_ADDR);
  assign rsel_enable = (s_axi_araddr == DFR_ENABLE_ADDR);
  assign rsel_mapped = rsel_analog || rsel_digital || rsel_irq_status
    || rsel_irq_mask || rsel_enable;

  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  // address and data are taken in either order; response follows both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DFR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      // an unmapped write changes nothing and is answered with an error
      s_axi_bresp <= wsel_mapped ? DFR_RESP_OKAY : DFR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // write-one-to-clear decode
  // ---------------------------------------------------------------
  // writing zero leaves a flag alone; bytes without strobe clear nothing
  always_comb begin
    clr_analog = 14'h0000;
    clr_digital = 2'h0;
    clr_irq = 2'h0;
    if (do_write && aw_addr == DFR_ANALOG_ADDR) begin
      if (w_strb[0]) clr_analog[7:0] = w_data[7:0];
      if (w_strb[1]) clr_analog[13:8] = w_data[13:8] & DFR_ANALOG_FLAG_MASK[13:8];
    end
    if (do_write && aw_addr == DFR_DIGITAL_ADDR && w_strb[0]) begin
      clr_digital = w_data[1:0];
    end
    if (do_write && aw_addr == DFR_IRQ_STATUS_ADDR && w_strb[0]) begin
      clr_irq = w_data[1:0];
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_mask <= 2'h0;
    end else if (do_write && wsel_irq_mask && w_strb[0]) begin
      irq_mask <= w_data[1:0];
    end
  end

  // each byte lane of the enable word follows its own strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      diag_enable <= DFR_ENABLE_RESET;
    end else if (do_write && wsel_enable) begin
      if (w_strb[0]) diag_enable[7:0] <= w_data[7:0];
      if (w_strb[1]) diag_enable[13:8] <= w_data[13:8];
    end
  end

  // ---------------------------------------------------------------
  // analog flag cells
  // ---------------------------------------------------------------
  // one cell per bit position; a reserved position holds a constant zero,
  // so neither a stray event nor a write can make it read back as one
  // bits 13 11 9 8 7 6 5..4 3/0 2 1
  for (genvar g = 0; g < FLAG_COUNT; g++) begin : g_analog
    if (DFR_ANALOG_FLAG_MASK[g]) begin : g_live
      // a disabled check never latches
      assign set_analog[g] = analog_event[g] & diag_enable[g];
      // set beats clear in the same cycle, so no event is lost
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          analog_flags[g] <= DFR_ANALOG_RESET[g];
        end else if (set_analog[g]) begin
          analog_flags[g] <= 1'b1;
        end else if (clr_analog[g]) begin
          analog_flags[g] <= 1'b0;
        end
      end
    end else begin : g_reserved
      assign set_analog[g] = 1'b0;
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          analog_flags[g] <= 1'b0;
        end else begin
          analog_flags[g] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // digital flag cells
  // ---------------------------------------------------------------
  // the word checks are evaluated only in the cycle the word is presented
  always_comb begin
    set_digital = 2'h0;
    if (frame_valid) begin
      set_digital[DFR_SLIP_BIT] = (frame_msb == frame_msb_less1);
      set_digital[DFR_CRC_BIT] = frame_crc_bad;
    end
  end

  // set beats clear here too: a frame error during a clear stays visible
  for (genvar g = 0; g < DIGITAL_COUNT; g++) begin : g_digital
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        digital_flags[g] <= DFR_DIGITAL_RESET[g];
      end else if (set_digital[g]) begin
        digital_flags[g] <= 1'b1;
      end else if (clr_digital[g]) begin
        digital_flags[g] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  // status records set events, not flag levels, so a disabled check never
  // raises the line and a cleared status stays quiet
  assign irq_source = {|set_digital, |set_analog};

  for (genvar g = 0; g < 2; g++) begin : g_irq
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        irq_status[g] <= DFR_IRQ_RESET[g];
      end else if (irq_source[g]) begin
        irq_status[g] <= 1'b1;
      end else if (clr_irq[g]) begin
        irq_status[g] <= 1'b0;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  // flags of disabled checks read as zero even if latched earlier; the
  // stored flag survives and shows again once the check is re-enabled
  for (genvar g = 0; g < FLAG_COUNT; g++) begin : g_readback
    assign flag_view[g] = analog_flags[g] & diag_enable[g];
  end

  always_comb begin
    analog_word = 22'h000000;
    analog_word[13:0] = flag_view & DFR_ANALOG_FLAG_MASK;
    analog_word[DFR_ADDR_MSB:DFR_ADDR_LSB] = DFR_ANALOG_INDEX;
    analog_word[DFR_FAULT_PIN_BIT] = !fault_pin;
  end

  // full read words, unused upper bits zero
  assign rv_analog = {10'h000, analog_word};
  assign rv_digital = {30'h0000000, digital_flags};
  assign rv_irq_status = {30'h0000000, irq_status};
  assign rv_irq_mask = {30'h0000000, irq_mask};
  assign rv_enable = {18'h00000, diag_enable};

  // an unmapped read returns zero with an error response
  always_comb begin
    next_rdata = 32'h00000000;
    next_rresp_err = !rsel_mapped;
    if (rsel_analog) next_rdata = rv_analog;
    if (rsel_digital) next_rdata = rv_digital;
    if (rsel_irq_status) next_rdata = rv_irq_status;
    if (rsel_irq_mask) next_rdata = rv_irq_mask;
    if (rsel_enable) next_rdata = rv_enable;
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= DFR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp_err ? DFR_RESP_SLVERR : DFR_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- test/dfr_flags_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
module dfr_flags_assertions
  import dfr_pkg::*;
(
  input wire logic mclk, reset_n, fault_pin,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic s_axi_bvalid, s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_ar(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  sequence s_ana_rd;
    s_ar(DFR_ANALOG_ADDR);
  endsequence
  AST_PIN:
  assert property (s_ana_rd |=> s_axi_rvalid && s_axi_rdata[21] == !$past(fault_pin))
    else $error("pin bit wrong");
  AST_ADDR:
  assert property (s_ana_rd |=> s_axi_rdata[20:16] == DFR_ANALOG_INDEX)
    else $error("address field wrong");
  AST_RSVD:
  assert property (s_ana_rd |=> s_axi_rdata[31:22] == 0 && s_axi_rdata[15:14] == 0
      && !s_axi_rdata[12] && !s_axi_rdata[10])
    else $error("reserved bit set");
  AST_DIG:
  assert property (s_ar(DFR_DIGITAL_ADDR) |=> s_axi_rdata[31:2] == 0)
    else $error("digital word too wide");
  AST_RHOLD:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_RDROP:
  assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read valid stuck");
  AST_BHOLD:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  AST_RRESP:
  assert property (s_ana_rd |=> s_axi_rresp == DFR_RESP_OKAY)
    else $error("analog read response wrong");
  AST_ARBLK:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule
bind dfr_flags dfr_flags_assertions dfr_flags_assertions_inst (.*);
`default_nettype wire

// ---- test/dfr_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module dfr_host (
  input wire logic mclk, s_axi_awready, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_arready, s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  output logic [7:0] s_axi_awaddr, s_axi_araddr,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready
);
  int tmo = 0;
  int lag = 0;
  initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = 0;
  initial {s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
  // released payload is inverted so a late sample never looks valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 2'b11, lag == 0};
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= n + 1 >= lag;
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
    if (n == 64) tmo++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'b1, lag == 0};
    for (n = 0; n < 64; n++) begin
      @(posedge mclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= n + 1 >= lag;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    if (n == 64) tmo++;
  endtask
endmodule
`default_nettype wire

// ---- test/dfr_flags_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module dfr_flags_bench;
  import dfr_pkg::*;
  logic mclk = 0, reset_n = 0, frame_valid = 0, frame_msb = 0, frame_msb_less1 = 0;
  logic frame_crc_bad = 0, fault_pin = 1, irq;
  logic [13:0] analog_event = 0, f;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int errors = 0, checks = 0, i, seed = 93;
  always #20 mclk = ~mclk;
  dfr_flags dfr_flags_inst (.*);
  dfr_host dfr_host_inst (.*);
  function automatic logic [31:0] ana(input logic [13:0] x, input logic p);
    return {10'h0, !p, DFR_ANALOG_INDEX, 2'h0, x & DFR_ANALOG_FLAG_MASK};
  endfunction
  task cmpw(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
  endtask
  task cmpb(input logic g, e);
    checks++;
    if (g !== e) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
  endtask
  task summarize;
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task guard;
    if (dfr_host_inst.tmo > 0) begin errors++; summarize; end
  endtask
  task wrc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
    dfr_host_inst.wr(a, x, r);
    guard;
    cmpw({30'h0, r}, {30'h0, e});
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    dfr_host_inst.rd(a, d, r);
    guard;
    cmpw(d, e);
    cmpw({30'h0, r}, {30'h0, er});
  endtask
  task ping(input logic [13:0] e);
    logic [31:0] p;
    @(posedge mclk);
    p = $random(seed);
    {analog_event, fault_pin} <= {e, p[0]};
    @(posedge mclk);
    analog_event <= 0;
  endtask
  task frame(input logic m, l, c);
    @(posedge mclk);
    {frame_valid, frame_msb, frame_msb_less1, frame_crc_bad} <= {1'b1, m, l, c};
    @(posedge mclk);
    frame_valid <= 0;
  endtask
  task irqc(input logic e);
    @(negedge mclk);
    cmpb(irq, e);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1;
    rdc(DFR_ANALOG_ADDR, ana(0, 1), DFR_RESP_OKAY);
    rdc(DFR_ENABLE_ADDR, 32'h3FFF, DFR_RESP_OKAY);
    for (i = 0; i < 14; i++) begin
      ping(14'h1 << i);
      rdc(DFR_ANALOG_ADDR, ana(14'h1 << i, fault_pin), DFR_RESP_OKAY);
      wrc(DFR_ANALOG_ADDR, 0, DFR_RESP_OKAY);
      rdc(DFR_ANALOG_ADDR, ana(14'h1 << i, fault_pin), DFR_RESP_OKAY);
      wrc(DFR_ANALOG_ADDR, 32'h1 << i, DFR_RESP_OKAY);
      rdc(DFR_ANALOG_ADDR, ana(0, fault_pin), DFR_RESP_OKAY);
    end
    f = 0;
    dfr_host_inst.lag = 3;
    repeat (20) begin
      q = $random(seed);
      ping(q[13:0]);
      wrc(DFR_ANALOG_ADDR, {18'h0, q[27:14]}, DFR_RESP_OKAY);
      f = (f | q[13:0]) & ~q[27:14];
      rdc(DFR_ANALOG_ADDR, ana(f, fault_pin), DFR_RESP_OKAY);
    end
    dfr_host_inst.lag = 0;
    wrc(DFR_ANALOG_ADDR, 32'h3FFF, DFR_RESP_OKAY);
    ping(14'h8);
    wrc(DFR_ENABLE_ADDR, 0, DFR_RESP_OKAY);
    ping(14'h3FFF);
    rdc(DFR_ANALOG_ADDR, ana(0, fault_pin), DFR_RESP_OKAY);
    wrc(DFR_ENABLE_ADDR, 32'h3FFF, DFR_RESP_OKAY);
    rdc(DFR_ANALOG_ADDR, ana(14'h8, fault_pin), DFR_RESP_OKAY);
    wrc(DFR_IRQ_STATUS_ADDR, 3, DFR_RESP_OKAY);
    irqc(0);
    wrc(DFR_IRQ_MASK_ADDR, 3, DFR_RESP_OKAY);
    frame(1, 1, 0);
    irqc(1);
    rdc(DFR_DIGITAL_ADDR, 2, DFR_RESP_OKAY);
    frame(0, 1, 1);
    rdc(DFR_DIGITAL_ADDR, 3, DFR_RESP_OKAY);
    frame(1, 0, 0);
    rdc(DFR_DIGITAL_ADDR, 3, DFR_RESP_OKAY);
    wrc(DFR_DIGITAL_ADDR, 1, DFR_RESP_OKAY);
    rdc(DFR_DIGITAL_ADDR, 2, DFR_RESP_OKAY);
    wrc(DFR_DIGITAL_ADDR, 2, DFR_RESP_OKAY);
    rdc(DFR_DIGITAL_ADDR, 0, DFR_RESP_OKAY);
    wrc(DFR_IRQ_MASK_ADDR, 0, DFR_RESP_OKAY);
    irqc(0);
    wrc(DFR_IRQ_MASK_ADDR, 3, DFR_RESP_OKAY);
    irqc(1);
    wrc(DFR_IRQ_STATUS_ADDR, 3, DFR_RESP_OKAY);
    irqc(0);
    rdc(8'h70, 0, DFR_RESP_SLVERR);
    wrc(8'h70, 32'hFFFF, DFR_RESP_SLVERR);
    summarize;
  end
endmodule
`default_nettype wire
